// ==== logic/cbfs_pkg.sv ====
`default_nettype none
package cbfs_pkg;

  // ==========================================================
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned MS_CYCLES     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned PRE_W         = 18;

  // ==========================================================
  // flash pattern timing
  localparam int unsigned CYCLE_MS      = 800;
  localparam int unsigned FLASH_PER_MIN = 75;
  localparam int unsigned STEP_MS       = 50;
  localparam int unsigned LONG_OFF_MS   = 250;
  localparam int unsigned STEP_W        = 4;
  localparam int unsigned SDUR_W        = 8;
  localparam logic [STEP_W-1:0] FIRST_STEP = 4'h0;
  localparam logic [STEP_W-1:0] LAST_STEP  = 4'hb;
  localparam logic [STEP_W-1:0] WIGWAG_END = 4'h8;

  // ==========================================================
  // operating period
  localparam int unsigned OPT_W = 20;

  // ==========================================================
  // types
  typedef enum logic {
    CBFS_IDLE,
    CBFS_FLASH
  } cbfs_state_type;

  typedef struct packed {
    logic left;
    logic right;
  } cbfs_lamps_type;

  typedef struct packed {
    logic start;
    logic stop;
  } cbfs_sync_type;

endpackage
`default_nettype wire

// ==== logic/cbfs_down_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module cbfs_down_timer #(
  parameter int unsigned W = 8
) (
  // clock
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  // count
  output var  logic [W-1:0] cnt_q
);

  // ==========================================================
  // counter: load beats decrement, stops at zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (load)
      begin
        cnt_q <= load_val;
      end
      else if (dec && cnt_q != '0)
      begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/cbfs_beacon_sequencer.sv ====
// Function
// [RULE1] separate left and right yellow outputs
// [RULE2] repeat an 800 ms flash cycle
// [RULE3] left on 50 ms, then off 50 ms
// [RULE4] right on 50 ms, off, alternating twice
// [RULE5] both on, off, both on, 50 ms each
// [RULE6] cycle ends with 250 ms dark
// [RULE7] per-output flash rate outside 5..30 Hz
// [RULE8] dark when idle, flash only after actuation
// [RULE9] pushbutton press starts flashing
// [RULE10] stop when operating period elapses
// [RULE11] stop when detector reports crosswalk cleared
// [RULE12] operating period configurable, applies per actuation
// [RULE13] companion beacons start and stop together
// [RULE14] confirmation lamp lit while operating
// [RULE15] start at first step, stop dark at once
// [RULE16] press while flashing restarts period, keeps phase
`timescale 1ns/1ns
`default_nettype none
module cbfs_beacon_sequencer #(
  parameter int unsigned CYC_PER_MS = cbfs_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // pedestrian side
  input  wire logic                         push_btn,
  input  wire logic                         ped_cleared,
  input  wire logic [cbfs_pkg::OPT_W-1:0]   op_time_ms,
  // companion beacons
  input  wire cbfs_pkg::cbfs_sync_type      sync_in,
  output var  cbfs_pkg::cbfs_sync_type      sync_q,
  // lamp drivers
  output var  cbfs_pkg::cbfs_lamps_type     lamps_q,
  output var  logic                         confirm_q
);
  import cbfs_pkg::*;

  // ==========================================================
  // declarations
  cbfs_state_type     state_q;
  cbfs_state_type     state_d;
  logic [STEP_W-1:0]  step_q;
  logic [STEP_W-1:0]  step_d;
  logic [STEP_W-1:0]  step_nxt;
  logic [PRE_W-1:0]   pre_cnt;
  logic [SDUR_W-1:0]  step_cnt;
  logic [SDUR_W-1:0]  step_val;
  logic [OPT_W-1:0]   op_cnt;
  logic [OPT_W-1:0]   op_val;
  cbfs_lamps_type     lamps_d;
  logic               active;
  logic               start_req;
  logic               go;
  logic               ms_tick;
  logic               step_end;
  logic               step_load;
  logic               op_load;
  logic               op_expire;
  logic               local_stop;
  logic               stop_evt;

  // ==========================================================
  // start and stop events
  assign active    = (state_q == CBFS_FLASH);
  // [RULE9] button or companion
  assign start_req = push_btn | sync_in.start;
  // [RULE8] only an actuation starts
  assign go        = !active && start_req;
  // [RULE10] [RULE11] local stop causes
  assign local_stop = active && (ped_cleared || op_expire);
  // [RULE13] companion stop joins
  assign stop_evt  = local_stop || (active && sync_in.stop);

  // ==========================================================
  // millisecond prescaler, runs only while flashing
  assign ms_tick = active && (pre_cnt == '0);

  cbfs_down_timer #(
    .W (PRE_W)
  ) u_prescale (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (go || ms_tick),
    .load_val (PRE_W'(CYC_PER_MS - 1)),
    .dec      (active),
    .cnt_q    (pre_cnt)
  );

  // ==========================================================
  // step timer
  assign step_end  = ms_tick && (step_cnt == '0);
  assign step_load = go || step_end;
  assign step_nxt  = (step_q == LAST_STEP) ? FIRST_STEP
                                           : step_q + STEP_W'(1);

  // [RULE6] last step holds the long dark gap
  always_comb
  begin
    step_val = SDUR_W'(STEP_MS - 1);
    if (!go && step_nxt == LAST_STEP)
    begin
      step_val = SDUR_W'(LONG_OFF_MS - 1);
    end
  end

  cbfs_down_timer #(
    .W (SDUR_W)
  ) u_step_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (step_load),
    .load_val (step_val),
    .dec      (ms_tick),
    .cnt_q    (step_cnt)
  );

  // ==========================================================
  // operating period timer
  // [RULE12] [RULE16] reload on every press outside a stop cycle
  assign op_load   = go || (active && push_btn && !stop_evt);
  // zero setting still gives one millisecond, never an endless run
  assign op_val    = (op_time_ms == '0) ? '0 : op_time_ms - OPT_W'(1);
  assign op_expire = ms_tick && (op_cnt == '0);

  cbfs_down_timer #(
    .W (OPT_W)
  ) u_op_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (op_load),
    .load_val (op_val),
    .dec      (ms_tick),
    .cnt_q    (op_cnt)
  );

  // ==========================================================
  // next state and step
  always_comb
  begin
    state_d = state_q;
    step_d  = step_q;
    // [RULE15] stop wins, back to first step
    if (stop_evt)
    begin
      state_d = CBFS_IDLE;
      step_d  = FIRST_STEP;
    end
    else if (go)
    begin
      state_d = CBFS_FLASH;
      step_d  = FIRST_STEP;
    end
    // [RULE2] advance and wrap every cycle
    else if (step_end)
    begin
      step_d = step_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CBFS_IDLE;
      step_q  <= FIRST_STEP;
    end
    else if (ce)
    begin
      state_q <= state_d;
      step_q  <= step_d;
    end
  end

  // ==========================================================
  // lamp pattern, decoded from next step so lamps align with step_q
  always_comb
  begin
    lamps_d = '0;
    if (state_d == CBFS_FLASH)
    begin
      unique case (step_d)
        // [RULE3] left steps
        4'h0, 4'h4: lamps_d.left = 1'b1;
        // [RULE4] right steps
        4'h2, 4'h6: lamps_d.right = 1'b1;
        // [RULE5] strobe steps
        4'h8, 4'ha: lamps_d = '{left: 1'b1, right: 1'b1};
        // [RULE7] odd steps stay dark
        default: lamps_d = '0;
      endcase
    end
  end

  // [RULE1] [RULE14] registered drivers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lamps_q   <= '0;
      confirm_q <= 1'b0;
    end
    else if (ce)
    begin
      lamps_q   <= lamps_d;
      confirm_q <= (state_d == CBFS_FLASH);
    end
  end

  // ==========================================================
  // companion sync: only local causes are sent, so no echo loops
  // [RULE13] one-cycle start and stop pulses
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= '0;
    end
    else if (ce)
    begin
      sync_q.start <= go && push_btn;
      sync_q.stop  <= local_stop;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_IDLE_DARK: assert property ( // RULE8
    state_q == CBFS_IDLE |-> lamps_q == '0 && !confirm_q)
    else $error("lamps lit while idle");

  AST_GO_FIRST_LEFT: assert property ( // RULE15
    ce && go |=> lamps_q.left && !lamps_q.right && step_q == FIRST_STEP
                 && confirm_q)
    else $error("activation did not begin with left step");

  AST_STOP_DARK: assert property ( // RULE10
    ce && stop_evt |=> state_q == CBFS_IDLE && lamps_q == '0
                       && !confirm_q && step_q == FIRST_STEP)
    else $error("stop did not darken at once");

  AST_STEP_ADVANCE: assert property ( // RULE2
    ce && step_end && !stop_evt |=> step_q == $past(step_nxt))
    else $error("step did not advance on its timer");

  AST_LONG_OFF: assert property ( // RULE6
    ce && step_end && !stop_evt && step_nxt == LAST_STEP
    |=> step_cnt == SDUR_W'(LONG_OFF_MS - 1) && lamps_q == '0)
    else $error("final dark step not loaded with long gap");

  AST_WIGWAG_EXCL: assert property ( // RULE4
    state_q == CBFS_FLASH && step_q < WIGWAG_END
    |-> !(lamps_q.left && lamps_q.right))
    else $error("both lamps on during wig-wag");

  AST_ODD_DARK: assert property ( // RULE7
    state_q == CBFS_FLASH && step_q[0] |-> lamps_q == '0)
    else $error("no dark gap between flashes");

  AST_STROBE_BOTH: assert property ( // RULE5
    state_q == CBFS_FLASH && (step_q == 4'h8 || step_q == 4'ha)
    |-> lamps_q.left && lamps_q.right)
    else $error("strobe step not lit on both sides");

  AST_RESTART: assert property ( // RULE16
    ce && active && push_btn && !stop_evt && !step_end
    |=> $stable(step_q) && op_cnt == $past(op_val))
    else $error("press while flashing disturbed phase or timer");

  AST_SYNC_START: assert property ( // RULE13
    ce && go && push_btn |=> sync_q.start && state_q == CBFS_FLASH)
    else $error("companion start pulse wrong");

  AST_SYNC_ONE: assert property ( // RULE13
    ce && go && push_btn ##1 ce |=> !sync_q.start)
    else $error("companion start pulse longer than one cycle");

  AST_COMPANION_START: assert property ( // RULE13
    ce && go && !push_btn |=> state_q == CBFS_FLASH && !sync_q.start)
    else $error("companion start echoed or not taken");

  AST_COMPANION_STOP: assert property ( // RULE13
    ce && active && sync_in.stop && !local_stop
    |=> !sync_q.stop && !confirm_q)
    else $error("companion stop echoed or not taken");

  AST_DETECT_STOP: assert property ( // RULE11
    ce && active && ped_cleared |=> sync_q.stop && !confirm_q)
    else $error("detector clear did not stop and notify");

  AST_EXPIRE_STOP: assert property ( // RULE10
    ce && op_expire |=> state_q == CBFS_IDLE && sync_q.stop && !confirm_q)
    else $error("operating period expiry did not stop and notify");

  AST_CONFIRM_ACTIVE: assert property ( // RULE14
    confirm_q == (state_q == CBFS_FLASH))
    else $error("confirmation lamp does not match operation");

  // a low enable must hold every output, or step timing drifts
  AST_CE_FREEZE: assert property ( // RULE2
    !ce |=> $stable(state_q) && $stable(step_q) && $stable(lamps_q)
            && $stable(confirm_q) && $stable(sync_q))
    else $error("state moved while clock enable was low");

endmodule
`default_nettype wire

// ==== tb/cbfs_ped_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cbfs_ped_model (
  // clock
  input  wire logic              core_clk,
  // pedestrian and companion side
  output var  logic              push_btn,
  output var  logic              ped_cleared,
  output var  cbfs_pkg::cbfs_sync_type sync_in
);
  import cbfs_pkg::*;

  // ==========================================================
  // idle levels
  initial
  begin
    push_btn    = 1'b0;
    ped_cleared = 1'b0;
    sync_in     = '0;
  end

  // ==========================================================
  // one-cycle events, mask is {button, cleared, start, stop}
  // companion start and stop
  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk);
    {push_btn, ped_cleared, sync_in} <= m;
    @(posedge core_clk);
    {push_btn, ped_cleared, sync_in} <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ==== tb/crosswalk_beacon_flash_sequencer_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module crosswalk_beacon_flash_sequencer_test;
  import cbfs_pkg::*;

  // ==========================================================
  // signals
  localparam int unsigned CPM      = 4;
  localparam int unsigned STEP_CYC = STEP_MS * CPM;
  localparam logic [23:0] PAT      = 24'h8484cc;
  localparam logic [3:0]  PRESS    = 4'h8;
  localparam logic [3:0]  CLEAR    = 4'h4;
  localparam logic [3:0]  CSTART   = 4'h2;
  localparam logic [3:0]  CSTOP    = 4'h1;
  logic                 core_clk;
  logic                 rst_n;
  logic                 ce;
  logic [OPT_W-1:0]     op_time_ms;
  logic                 push_btn;
  logic                 ped_cleared;
  cbfs_sync_type        sync_in;
  cbfs_sync_type        sync_q;
  cbfs_lamps_type       lamps_q;
  logic                 confirm_q;
  int unsigned          err_count;
  int unsigned          comparisons;

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  cbfs_beacon_sequencer #(.CYC_PER_MS(CPM)) DUT (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .push_btn    (push_btn),
    .ped_cleared (ped_cleared),
    .op_time_ms  (op_time_ms),
    .sync_in     (sync_in),
    .sync_q      (sync_q),
    .lamps_q     (lamps_q),
    .confirm_q   (confirm_q)
  );

  cbfs_ped_model ped (
    .core_clk    (core_clk),
    .push_btn    (push_btn),
    .ped_cleared (ped_cleared),
    .sync_in     (sync_in)
  );

  // ==========================================================
  // helpers
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic step(input int unsigned n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // result is {left, right, confirm, sync start, sync stop}
  task automatic check(input logic [4:0] exp);
    logic [4:0] got;
    got = {lamps_q, confirm_q, sync_q};
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_period(input logic [OPT_W-1:0] ms);
    @(posedge core_clk);
    op_time_ms <= ms;
  endtask

  // ==========================================================
  // scenarios
  task automatic idle_dark();
    check(5'h00);
    ped.pulse(CLEAR | CSTOP);
    step(0);
    check(5'h00);
  endtask

  // sampled mid-step so a one-cycle step skew is tolerated
  task automatic full_pattern();
    set_period(20'd1000);
    ped.pulse(PRESS);
    step(0);
    check(5'b10110);
    step(1);
    check(5'b10100);
    step(STEP_CYC / 2 - 1);
    for (int k = 0; k < 12; k++)
    begin
      check({PAT[23 - 2 * k -: 2], 3'b100});
      step((k == 11 ? LONG_OFF_MS / STEP_MS : 1) * STEP_CYC);
    end
    check(5'b10100);
    ped.pulse(CLEAR);
    step(0);
    check(5'b00001);
    step(1);
    check(5'b00000);
  endtask

  task automatic timer_expiry();
    set_period(20'd3);
    ped.pulse(PRESS);
    step(0);
    check(5'b10110);
    step(11);
    check(5'b10100);
    step(1);
    check(5'b00001);
    step(7);
    check(5'b00000);
  endtask

  // without the reload the period would already be over at c14
  task automatic press_reload();
    set_period(20'd3);
    ped.pulse(PRESS);
    step(6);
    ped.pulse(PRESS);
    step(6);
    check(5'b10100);
    step(6);
    check(5'b00001);
    step(14);
    check(5'b00000);
  endtask

  // companion events are not echoed back
  task automatic companion();
    set_period(20'd1000);
    ped.pulse(CSTART);
    step(0);
    check(5'b10100);
    step(5);
    ped.pulse(CSTOP);
    step(0);
    check(5'b00000);
  endtask

  // a low enable freezes the beacon and hides the detector
  task automatic freeze();
    set_period(20'd1000);
    ped.pulse(PRESS);
    @(posedge core_clk);
    ce <= 1'b0;
    ped.pulse(CLEAR);
    step(0);
    check(5'b10100);
    @(posedge core_clk);
    ce <= 1'b1;
    step(1);
    check(5'b10100);
    ped.pulse(CLEAR);
    step(0);
    check(5'b00001);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    core_clk    = 1'b0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    op_time_ms  = '0;
    err_count   = 0;
    comparisons = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    step(1);
    idle_dark();
    full_pattern();
    timer_expiry();
    press_reload();
    companion();
    freeze();
    complete_run();
  end

  // whole run is about 3400 cycles
  initial
  begin
    #(20000 * CLK_PERIOD_NS);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
